// ==== src/acrb_top.sv ====
/*
 * Control and status register bank of a mono digital-input amplifier,
 * reached over a two-wire control bus (open drain data line).
 * Assumes scl and the data line come from pins; samples, the supply reading
 * and the fault status come from logic on core_clk.
 */
// Notes on behaviour
// - 2048 consecutive zero samples enter low power
// - nonzero sample wakes and restarts count
// - power bit 7 enables auto sleep, resets 1
// - power bit 6 switches supply sense off
// - writing power bit 1 resets the registers, the sleep count and the blocks, not the bus slave
// - power bit 0 holds blocks low power
// - power register at 0x00, resets 0x81
// - gain bit 4 selects slow edge rate
// - gain bits 1:0 select full-scale range
// - gain register at 0x01, resets 0x01
`include "acrb_map.svh"

module acrb_top #(
    parameter logic [6:0] DEV_ADDR = 7'h2a // arbitrary bus address
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic clkEn,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire acrb_pkg::acrb_sample_t sampleIn,
    input wire logic [7:0] supplyReading,
    input wire logic [7:0] faultStatus,
    output logic lowPower,
    output logic autoSleep,
    output logic blockReset,
    output logic supplySenseOff,
    output logic slowEdge,
    output logic [1:0] outputGainRange,
    output acrb_pkg::acrb_ctrl_t ctrlBank
);

    logic [7:0] ctrlRegs_q [0:`ACRB_REG_COUNT-1];
    logic [1:0] sclSync_q, sdaSync_q;
    logic sclLast_q, sdaLast_q;
    acrb_pkg::acrb_state_t state_q;
    logic ackPhase_q;
    logic [3:0] bitCnt_q;
    logic [7:0] shift_q, rdShift_q, ptr_q;
    logic wrEn_q;
    logic [7:0] wrAddr_q, wrData_q;
    logic sdaOe_q;
    logic [`ACRB_ZERO_CNT_W-1:0] zeroCnt_q;
    logic autoSleep_q, lowPower_q, blockReset_q;
    logic sclRise, sclFall, startSeen, stopSeen, sdaNow;
    logic softReset;
    logic [7:0] rdByte;

    // reset value of each storage slot
    function automatic logic [7:0] defaultOf(input int idx);
        case (idx)
            0: defaultOf = `ACRB_RST_POWER;
            1: defaultOf = `ACRB_RST_GAIN_EDGE;
            2: defaultOf = `ACRB_RST_CONVERTER;
            3: defaultOf = `ACRB_RST_VOLUME;
            4: defaultOf = `ACRB_RST_SERIAL_A;
            5: defaultOf = `ACRB_RST_SERIAL_B;
            7: defaultOf = `ACRB_RST_LIMITER_A;
            8: defaultOf = `ACRB_RST_LIMITER_B;
            9: defaultOf = `ACRB_RST_LIMITER_C;
            11: defaultOf = `ACRB_RST_FAULT_REC;
            default: defaultOf = 8'h00;
        endcase
    endfunction : defaultOf

    // two flip-flop synchronisers on the bus pins, plus a delayed copy
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sclSync_q <= 2'h3;
            sdaSync_q <= 2'h3;
            sclLast_q <= 1'b1;
            sdaLast_q <= 1'b1;
        end else if (clkEn) begin
            sclSync_q <= {sclSync_q[0], sclIn};
            sdaSync_q <= {sdaSync_q[0], sdaIn};
            sclLast_q <= sclSync_q[1];
            sdaLast_q <= sdaSync_q[1];
        end
    end

    // bus events seen on the synchronised lines
    assign sdaNow = sdaSync_q[1];
    assign sclRise = sclSync_q[1] && !sclLast_q;
    assign sclFall = !sclSync_q[1] && sclLast_q;
    assign startSeen = sclSync_q[1] && sclLast_q && !sdaNow && sdaLast_q;
    assign stopSeen = sclSync_q[1] && sclLast_q && sdaNow && !sdaLast_q;

    // read data: soft reset bit and unmapped offsets read as zero
    always_comb begin
        rdByte = 8'h00;
        if (ptr_q == `ACRB_OFS_SUPPLY_READ) begin
            rdByte = supplyReading;
        end else if (ptr_q == `ACRB_OFS_FAULT_STAT) begin
            rdByte = faultStatus;
        end else if (ptr_q < 8'(`ACRB_REG_COUNT)) begin
            rdByte = ctrlRegs_q[ptr_q[3:0]];
        end
    end

    // two-wire slave: address, register pointer, write bytes or read bytes
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= acrb_pkg::ACRB_IDLE;
            ackPhase_q <= 1'b0;
            bitCnt_q <= 4'h0;
            shift_q <= 8'h00;
            rdShift_q <= 8'h00;
            ptr_q <= 8'h00;
            wrEn_q <= 1'b0;
            wrAddr_q <= 8'h00;
            wrData_q <= 8'h00;
            sdaOe_q <= 1'b0;
        end else if (clkEn) begin
            wrEn_q <= 1'b0;
            if (startSeen) begin
                state_q <= acrb_pkg::ACRB_DEVADDR;
                ackPhase_q <= 1'b0;
                bitCnt_q <= 4'h0;
                sdaOe_q <= 1'b0;
            end else if (stopSeen) begin
                state_q <= acrb_pkg::ACRB_IDLE;
                ackPhase_q <= 1'b0;
                sdaOe_q <= 1'b0;
            end else if (sclRise) begin
                if (state_q == acrb_pkg::ACRB_READ) begin
                    if (ackPhase_q && sdaNow && !sdaOe_q) begin
                        state_q <= acrb_pkg::ACRB_IDLE; // host ends the read
                        ackPhase_q <= 1'b0;
                    end
                end else if (state_q != acrb_pkg::ACRB_IDLE && !ackPhase_q) begin
                    shift_q <= {shift_q[6:0], sdaNow};
                    bitCnt_q <= bitCnt_q + 4'h1;
                end
            end else if (sclFall) begin
                if (state_q == acrb_pkg::ACRB_READ) begin
                    if (ackPhase_q) begin
                        ackPhase_q <= 1'b0;
                        sdaOe_q <= !rdByte[7];
                        rdShift_q <= {rdByte[6:0], 1'b0};
                        bitCnt_q <= 4'h1;
                    end else if (bitCnt_q == 4'h8) begin
                        ackPhase_q <= 1'b1; // host drives its acknowledge
                        sdaOe_q <= 1'b0;
                        ptr_q <= ptr_q + 8'h01;
                    end else begin
                        sdaOe_q <= !rdShift_q[7];
                        rdShift_q <= {rdShift_q[6:0], 1'b0};
                        bitCnt_q <= bitCnt_q + 4'h1;
                    end
                end else if (ackPhase_q) begin
                    ackPhase_q <= 1'b0;
                    sdaOe_q <= 1'b0;
                    bitCnt_q <= 4'h0;
                end else if (bitCnt_q == 4'h8) begin
                    unique case (state_q)
                        acrb_pkg::ACRB_DEVADDR: begin
                            if (shift_q[7:1] == DEV_ADDR) begin
                                ackPhase_q <= 1'b1;
                                sdaOe_q <= 1'b1;
                                state_q <= shift_q[0] ? acrb_pkg::ACRB_READ
                                                      : acrb_pkg::ACRB_REGADDR;
                            end else begin
                                state_q <= acrb_pkg::ACRB_IDLE;
                            end
                        end
                        acrb_pkg::ACRB_REGADDR: begin
                            ptr_q <= shift_q;
                            ackPhase_q <= 1'b1;
                            sdaOe_q <= 1'b1;
                            state_q <= acrb_pkg::ACRB_WRITE;
                        end
                        acrb_pkg::ACRB_WRITE: begin
                            wrEn_q <= 1'b1;
                            wrAddr_q <= ptr_q;
                            wrData_q <= shift_q;
                            ptr_q <= ptr_q + 8'h01;
                            ackPhase_q <= 1'b1;
                            sdaOe_q <= 1'b1;
                        end
                        acrb_pkg::ACRB_IDLE, acrb_pkg::ACRB_READ: begin
                            state_q <= state_q;
                        end
                    endcase
                end
            end
        end
    end

    assign softReset = wrEn_q && wrAddr_q == `ACRB_OFS_POWER
                       && wrData_q[`ACRB_BIT_SOFT_RESET];

    // register storage; read-only and unmapped offsets ignore writes
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < `ACRB_REG_COUNT; i++) begin
                ctrlRegs_q[i] <= defaultOf(i);
            end
        end else if (clkEn) begin
            if (softReset) begin
                for (int i = 0; i < `ACRB_REG_COUNT; i++) begin
                    ctrlRegs_q[i] <= defaultOf(i);
                end
            end else if (wrEn_q && wrAddr_q < 8'(`ACRB_REG_COUNT)
                         && wrAddr_q != `ACRB_OFS_SUPPLY_READ
                         && wrAddr_q != `ACRB_OFS_FAULT_STAT) begin
                ctrlRegs_q[wrAddr_q[3:0]] <= wrData_q;
                if (wrAddr_q == `ACRB_OFS_POWER) begin
                    ctrlRegs_q[0][`ACRB_BIT_SOFT_RESET] <= 1'b0;
                end
            end
        end
    end

    // one-cycle reset pulse to the functional blocks
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            blockReset_q <= 1'b0;
        end else if (clkEn) begin
            blockReset_q <= softReset;
        end
    end

    // zero-sample run counter and auto sleep state
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            zeroCnt_q <= '0;
            autoSleep_q <= 1'b0;
        end else if (clkEn) begin
            if (softReset || !ctrlRegs_q[0][`ACRB_BIT_AUTO_SLEEP]) begin
                zeroCnt_q <= '0;
                autoSleep_q <= 1'b0;
            end else if (sampleIn.valid) begin
                if (sampleIn.data != '0) begin
                    zeroCnt_q <= '0;
                    autoSleep_q <= 1'b0;
                end else if (zeroCnt_q == `ACRB_ZERO_CNT_W'(`ACRB_ZERO_RUN - 1)) begin
                    autoSleep_q <= 1'b1;
                end else begin
                    zeroCnt_q <= zeroCnt_q + `ACRB_ZERO_CNT_W'(1);
                end
            end
        end
    end

    // low power request to every block but the control interface
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            lowPower_q <= 1'b1;
        end else if (clkEn) begin
            lowPower_q <= ctrlRegs_q[0][`ACRB_BIT_MASTER_PD] || autoSleep_q;
        end
    end

    // outputs
    assign sdaOut = 1'b0;
    assign sdaOe = sdaOe_q;
    assign lowPower = lowPower_q;
    assign autoSleep = autoSleep_q;
    assign blockReset = blockReset_q;
    assign supplySenseOff = ctrlRegs_q[0][`ACRB_BIT_SENSE_OFF];
    assign slowEdge = ctrlRegs_q[1][`ACRB_BIT_SLOW_EDGE];
    assign outputGainRange = ctrlRegs_q[1][1:0];
    assign ctrlBank = '{converter: ctrlRegs_q[2], volume: ctrlRegs_q[3],
                        serialA: ctrlRegs_q[4], serialB: ctrlRegs_q[5],
                        limiterA: ctrlRegs_q[7], limiterB: ctrlRegs_q[8],
                        limiterC: ctrlRegs_q[9], faultRec: ctrlRegs_q[11]};

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    // checks
    AST_SLEEP_ENTER: assert property (
        clkEn && ctrlRegs_q[0][7] && !softReset && sampleIn.valid
        && sampleIn.data == '0 && zeroCnt_q == 12'd2047 |=> autoSleep_q)
        else $error("auto sleep not entered after 2048 zeros");
    AST_SLEEP_CAUSE: assert property (
        $rose(autoSleep_q) |-> $past(zeroCnt_q) == 12'd2047)
        else $error("auto sleep entered early");
    AST_WAKE: assert property (
        clkEn && ctrlRegs_q[0][7] && sampleIn.valid && sampleIn.data != '0
        |=> !autoSleep_q && zeroCnt_q == '0)
        else $error("nonzero sample did not wake");
    AST_AUTO_OFF: assert property (
        clkEn && !ctrlRegs_q[0][7] |=> !autoSleep_q ##0 zeroCnt_q == '0)
        else $error("auto sleep active while disabled");
    AST_SENSE_WRITE: assert property (
        clkEn && wrEn_q && wrAddr_q == 8'h00 && !wrData_q[1]
        |=> supplySenseOff == $past(wrData_q[6]))
        else $error("supply sense bit not written");
    AST_SOFT_RESET: assert property (
        clkEn && softReset |=> blockReset_q && ctrlRegs_q[1] == 8'h01
        && ctrlRegs_q[0] == 8'h81 && ctrlRegs_q[7] == 8'ha4)
        else $error("soft reset did not restore defaults");
    AST_MASTER_PD: assert property (
        clkEn && ctrlRegs_q[0][0] |=> lowPower_q)
        else $error("master power-down not applied");
    AST_LOW_CAUSE: assert property (
        clkEn && !ctrlRegs_q[0][0] && !autoSleep_q |=> !lowPower_q)
        else $error("low power without a cause");
    AST_SRST_ZERO: assert property (
        !ctrlRegs_q[0][1] && !(ptr_q == 8'h00 && rdByte[1]))
        else $error("soft reset bit reads back set");
    AST_GAIN_WRITE: assert property (
        clkEn && wrEn_q && wrAddr_q == 8'h01 |=> slowEdge == $past(wrData_q[4])
        && outputGainRange == $past(wrData_q[1:0]))
        else $error("gain and edge register not written");
    AST_RO_KEPT: assert property (
        clkEn && wrEn_q && wrAddr_q == 8'h0a |=> $stable(ctrlRegs_q[10]))
        else $error("read-only offset took a write");
    AST_COUNT_STEP: assert property (
        clkEn && ctrlRegs_q[0][7] && !softReset && sampleIn.valid && sampleIn.data == '0
        && zeroCnt_q != 12'd2047 |=> zeroCnt_q == $past(zeroCnt_q) + 12'd1)
        else $error("zero sample not counted");
    AST_COUNT_HOLD: assert property (
        clkEn && ctrlRegs_q[0][7] && !softReset && !sampleIn.valid
        |=> $stable(zeroCnt_q) && $stable(autoSleep_q))
        else $error("zero count moved without a sample");
    AST_SLEEP_LOW: assert property (
        clkEn && autoSleep_q |=> lowPower_q)
        else $error("auto sleep did not request low power");
    AST_SLEEP_STAYS: assert property (
        clkEn && autoSleep_q && ctrlRegs_q[0][7] && !softReset
        && !(sampleIn.valid && sampleIn.data != '0) |=> autoSleep_q)
        else $error("auto sleep left without a nonzero sample");
    AST_AUTO_WRITE: assert property (
        clkEn && wrEn_q && wrAddr_q == 8'h00 && !wrData_q[1]
        |=> ctrlRegs_q[0][7] == $past(wrData_q[7]))
        else $error("auto sleep enable bit not written");
    AST_SRST_PULSE: assert property (
        clkEn && blockReset_q |=> !blockReset_q)
        else $error("block reset pulse longer than one cycle");
    AST_SRST_SLEEP: assert property (
        clkEn && softReset |=> zeroCnt_q == '0 && !autoSleep_q)
        else $error("soft reset left the sleep state");
    AST_PD_WRITE: assert property (
        clkEn && wrEn_q && wrAddr_q == 8'h00 && !wrData_q[1]
        |=> ctrlRegs_q[0][0] == $past(wrData_q[0]))
        else $error("master power-down bit not written");
    AST_GAIN_KEEP: assert property (
        clkEn && !softReset && !(wrEn_q && wrAddr_q == 8'h01) |=> $stable(ctrlRegs_q[1]))
        else $error("gain and edge register changed without a write");

endmodule : acrb_top

// ==== src/acrb_map.svh ====
/*
 * Register offsets, field positions, reset values and counts of the amplifier
 * control register bank. Assumes inclusion by acrb_pkg and acrb_top only.
 */
`ifndef ACRB_MAP_SVH
`define ACRB_MAP_SVH

// register offsets
`define ACRB_OFS_POWER 8'h00
`define ACRB_OFS_GAIN_EDGE 8'h01
`define ACRB_OFS_CONVERTER 8'h02
`define ACRB_OFS_VOLUME 8'h03
`define ACRB_OFS_SERIAL_A 8'h04
`define ACRB_OFS_SERIAL_B 8'h05
`define ACRB_OFS_SUPPLY_READ 8'h06
`define ACRB_OFS_LIMITER_A 8'h07
`define ACRB_OFS_LIMITER_B 8'h08
`define ACRB_OFS_LIMITER_C 8'h09
`define ACRB_OFS_FAULT_STAT 8'h0a
`define ACRB_OFS_FAULT_REC 8'h0b
`define ACRB_REG_COUNT 12

// reset values
`define ACRB_RST_POWER 8'h81
`define ACRB_RST_GAIN_EDGE 8'h01
`define ACRB_RST_CONVERTER 8'h32
`define ACRB_RST_VOLUME 8'h40
`define ACRB_RST_SERIAL_A 8'h11
`define ACRB_RST_SERIAL_B 8'h00
`define ACRB_RST_LIMITER_A 8'ha4
`define ACRB_RST_LIMITER_B 8'h00
`define ACRB_RST_LIMITER_C 8'h22
`define ACRB_RST_FAULT_REC 8'h18

// field positions
`define ACRB_BIT_AUTO_SLEEP 7
`define ACRB_BIT_SENSE_OFF 6
`define ACRB_BIT_SOFT_RESET 1
`define ACRB_BIT_MASTER_PD 0
`define ACRB_BIT_SLOW_EDGE 4

// zero samples before auto sleep, and counter width
`define ACRB_ZERO_RUN 2048
`define ACRB_ZERO_CNT_W 12
`define ACRB_SAMPLE_W 24

`endif

// ==== src/acrb_pkg.sv ====
/*
 * Types of the amplifier control register bank.
 * Assumes acrb_map.svh is on the include path.
 */
`include "acrb_map.svh"

package acrb_pkg;

    // one audio input sample
    typedef struct packed {
        logic valid;
        logic [`ACRB_SAMPLE_W-1:0] data;
    } acrb_sample_t;

    // register contents handed to the other functional blocks
    typedef struct packed {
        logic [7:0] converter;
        logic [7:0] volume;
        logic [7:0] serialA;
        logic [7:0] serialB;
        logic [7:0] limiterA;
        logic [7:0] limiterB;
        logic [7:0] limiterC;
        logic [7:0] faultRec;
    } acrb_ctrl_t;

    // two-wire slave phases
    typedef enum logic [2:0] {
        ACRB_IDLE,
        ACRB_DEVADDR,
        ACRB_REGADDR,
        ACRB_WRITE,
        ACRB_READ
    } acrb_state_t;

endpackage : acrb_pkg

// ==== verification/acrb_host.sv ====
/*
 * Two-wire bus host model that reaches the amplifier register bank.
 * Assumes the bench resolves the open-drain data line from both parties.
 */
module acrb_host #(
    parameter logic [6:0] DEV_ADDR = 7'h2a // arbitrary bus address
) (
    input wire logic core_clk,
    input wire logic sdaLine,
    output logic scl,
    output logic sdaLow
);
    timeunit 1ns;
    timeprecision 100ps;
    int nacks = 0;

    // idle bus: clock high, data released
    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask : tick

    // one bit; data only changes while the bus clock is low
    task automatic bit_io(input logic b, output logic r);
        sdaLow = ~b;
        tick(4);
        scl = 1'b1;
        tick(8);
        r = sdaLine;
        scl = 1'b0;
        tick(4);
    endtask : bit_io

    // start or repeated start: data falls while clock high
    task automatic start();
        sdaLow = 1'b0;
        tick(4);
        scl = 1'b1;
        tick(8);
        sdaLow = 1'b1;
        tick(8);
        scl = 1'b0;
        tick(4);
    endtask : start

    task automatic stop();
        sdaLow = 1'b1;
        tick(4);
        scl = 1'b1;
        tick(8);
        sdaLow = 1'b0;
        tick(8);
    endtask : stop

    // byte out msb first, then count a missing acknowledge
    task automatic put(input logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(b[i], r);
        bit_io(1'b1, r);
        if (r !== 1'b0) nacks++;
    endtask : put

    // callers pass zeros in reserved bits and skip read-only places
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        start();
        put({DEV_ADDR, 1'b0});
        put(a);
        put(d);
        stop();
    endtask : write_reg

    // pointer write, repeated start, one byte closed by a nack
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        logic r;
        start();
        put({DEV_ADDR, 1'b0});
        put(a);
        start();
        put({DEV_ADDR, 1'b1});
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(1'b1, r);
        stop();
    endtask : read_reg
endmodule : acrb_host

// ==== verification/amp_control_register_bank_bench.sv ====
/*
 * Self-checking bench of the amplifier control register bank.
 * Assumes acrb_pkg, acrb_top and the host model acrb_host are compiled first.
 */
module amp_control_register_bank_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    acrb_pkg::acrb_sample_t sampleIn = '0;
    logic scl, sdaLow, sdaOut, sdaOe, lowPower, autoSleep, blockReset, supplySenseOff, slowEdge;
    logic [1:0] outputGainRange;
    acrb_pkg::acrb_ctrl_t ctrlBank;
    logic [7:0] rd;
    logic [7:0] rstExp [13] = '{8'h81, 8'h01, 8'h32, 8'h40, 8'h11, 8'h00, 8'h5a, 8'ha4,
        8'h00, 8'h22, 8'h3c, 8'h18, 8'h00};
    int mismatches = 0;
    int comparisons = 0;
    int pulses = 0;
    // pull-up unless either party pulls the data line low
    wire logic sdaLine = ~(sdaLow | (sdaOe & ~sdaOut));

    initial begin
        forever #5 core_clk = ~core_clk;
    end

    acrb_host host (.core_clk(core_clk), .sdaLine(sdaLine), .scl(scl), .sdaLow(sdaLow));

    acrb_top dut (.core_clk(core_clk), .nrst(nrst), .clkEn(1'b1), .sclIn(scl), .sdaIn(sdaLine),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .sampleIn(sampleIn), .supplyReading(8'h5a),
        .faultStatus(8'h3c), .lowPower(lowPower), .autoSleep(autoSleep),
        .blockReset(blockReset), .supplySenseOff(supplySenseOff), .slowEdge(slowEdge),
        .outputGainRange(outputGainRange), .ctrlBank(ctrlBank));

    // count block reset pulses
    always @(negedge core_clk) begin
        if (blockReset === 1'b1) pulses++;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        host.read_reg(a, rd);
        check(rd, exp);
    endtask : rdchk

    // samples as one-cycle strobes, then let the sleep state settle
    task automatic feed(input int n, input logic [23:0] d);
        repeat (n) begin
            @(negedge core_clk);
            sampleIn = '{valid: 1'b1, data: d};
            @(negedge core_clk);
            sampleIn.valid = 1'b0;
        end
        repeat (2) @(negedge core_clk);
    endtask : feed

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up

    // main test sequence
    initial begin
        logic [7:0] v;
        repeat (2) @(negedge core_clk);
        nrst = 1'b1;
        repeat (4) @(negedge core_clk);
        check({7'h0, lowPower}, 8'h01);
        check({6'h0, outputGainRange}, 8'h01);
        check({6'h0, supplySenseOff, slowEdge}, 8'h00);
        check({7'h0, autoSleep}, 8'h00);
        for (int a = 0; a < 13; a++) rdchk(a[7:0], rstExp[a]);
        $display("test reset values done");
        for (int g = 0; g < 4; g++) begin
            v = {3'h0, g[0], 2'h0, g[1:0]};
            host.write_reg(8'h01, v);
            check({3'h0, slowEdge, 2'h0, outputGainRange}, v);
            rdchk(8'h01, v);
        end
        $display("test gain and edge done");
        host.write_reg(8'h00, 8'h40);
        check({6'h0, lowPower, supplySenseOff}, 8'h01);
        rdchk(8'h00, 8'h40);
        host.write_reg(8'h00, 8'h01);
        check({7'h0, lowPower}, 8'h01);
        rdchk(8'h00, 8'h01);
        $display("test power bits done");
        host.write_reg(8'h00, 8'h00);
        feed(2048, 24'h0);
        check({6'h0, lowPower, autoSleep}, 8'h00);
        host.write_reg(8'h00, 8'h80);
        feed(2047, 24'h0);
        check({6'h0, lowPower, autoSleep}, 8'h00);
        feed(1, 24'h0);
        check({6'h0, lowPower, autoSleep}, 8'h03);
        feed(1, 24'h000001);
        check({6'h0, lowPower, autoSleep}, 8'h00);
        feed(2047, 24'h0);
        check({6'h0, lowPower, autoSleep}, 8'h00);
        feed(1, 24'h0);
        check({6'h0, lowPower, autoSleep}, 8'h03);
        host.write_reg(8'h00, 8'h00);
        check({6'h0, lowPower, autoSleep}, 8'h00);
        $display("test auto sleep done");
        for (int k = 1; k < 3; k++) begin
            host.write_reg(8'h01, 8'h13);
            host.write_reg(8'h03, 8'h7f);
            host.write_reg(8'h00, 8'h42);
            check(pulses[7:0], k[7:0]);
            check({6'h0, lowPower, slowEdge}, 8'h02);
            check(ctrlBank.volume, 8'h40);
            rdchk(8'h00, 8'h81);
            rdchk(8'h01, 8'h01);
        end
        $display("test soft reset done");
        check(host.nacks[7:0], 8'h00);
        wrap_up();
    end

    // watchdog well beyond the expected run of about 35000 cycles
    initial begin
        #600000;
        mismatches++;
        $display("[FAIL] %0t watchdog expired", $time);
        wrap_up();
    end
endmodule : amp_control_register_bank_bench
